// *** svc_consts.svh ***
// constants for the servo command interpreter: codes, keys, timing
// assumes inclusion by svc_cmd_core, svc_chk and the testbench
`ifndef SVC_CONSTS_SVH
`define SVC_CONSTS_SVH
`define SVC_CMD_STAT_RD 8'h00
`define SVC_CMD_CUR_ALM 8'h02
`define SVC_CMD_STS_RD 8'h12
`define SVC_CMD_HIST_RD 8'h33
`define SVC_CMD_SNAP_RD 8'h35
`define SVC_CMD_CLEAR 8'h82
`define SVC_CMD_TEST 8'h8B
`define SVC_CMD_FORCE 8'h92
`define SVC_CMD_POS 8'hA0
`define SVC_CMD_PT_POS 8'h40
`define SVC_CMD_PT_SPD 8'h50
`define SVC_CMD_PT_ACC 8'h54
`define SVC_CMD_PT_DEC 8'h58
`define SVC_CMD_PT_DWL 8'h60
`define SVC_CMD_PT_AUX 8'h64
`define SVC_DN_ZERO 8'h00
`define SVC_DN_MODE 8'h12
`define SVC_DN_STS 8'h80
`define SVC_DN_HCODE_LO 8'h10
`define SVC_DN_HCODE_HI 8'h15
`define SVC_DN_HTIME_LO 8'h20
`define SVC_DN_HTIME_HI 8'h25
`define SVC_DN_SNAP_LO 8'h80
`define SVC_DN_SNAP_HI 8'h8E
`define SVC_DN_HCLR 8'h20
`define SVC_DN_POS 8'h41
`define SVC_DN_FORCE 8'hA0
`define SVC_KEY 16'h1EA5
`define SVC_TXT_STOP 32'h53544F50
`define SVC_TXT_GO 32'h474F2020
`define SVC_TXT_BLANK 32'h20202020
`define SVC_NO_ALARM 8'hFF
`define SVC_HOME_BIT 17
`define SVC_HIST_N 6
`define SVC_SNAP_N 15
`define SVC_PT_FIELDS 6
`define SVC_CLK_HZ 20000000
`define SVC_WDOG_MS 500
`define SVC_WDOG_CYC (`SVC_CLK_HZ / 1000 * `SVC_WDOG_MS)
`endif

// *** svc_pkg.sv ***
// types shared by the servo command interpreter
// assumes svc_consts.svh in the include path
package svc_pkg;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] dnum;
        logic [31:0] data;
    } svc_cmd_t;
    typedef struct packed {
        logic err;
        logic [7:0] info;
        logic [31:0] data;
    } svc_rsp_t;
    typedef struct packed {
        logic [7:0] info;
        logic [31:0] value;
    } svc_stat_t;
    typedef enum logic [2:0] {
        SVC_MODE_NORMAL = 3'h0,
        SVC_MODE_JOG = 3'h1,
        SVC_MODE_POSN = 3'h2,
        SVC_MODE_MOTORLESS = 3'h3,
        SVC_MODE_FORCE = 3'h4,
        SVC_MODE_STEP = 3'h5
    } svc_mode_t;
    typedef enum logic [1:0] {
        SVC_PS_FREE = 2'b01,
        SVC_PS_HOLD = 2'b10
    } svc_pos_t;
endpackage : svc_pkg

// *** svc_cmd_core.sv ***
// servo slave command interpreter: test modes, alarms, point table
// assumes one command per cmd_valid_i pulse, synchronous inputs
`timescale 1ns/100ps
`include "svc_consts.svh"
module svc_cmd_core #(
    parameter int WDOG_CYC = `SVC_WDOG_CYC,
    parameter int PT_DEPTH = 256
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // command from the master
    input wire logic cmd_valid_i,
    input svc_pkg::svc_cmd_t cmd_i,
    // reply to the master
    output logic rsp_valid_o,
    output svc_pkg::svc_rsp_t rsp_o,
    // motion status and control
    input wire logic pos_running_i,
    input wire logic home_return_done_flag_i,
    output logic pos_hold_o,
    output logic pos_resume_o,
    output logic pos_clear_o,
    output logic test_stop_o,
    output svc_pkg::svc_mode_t test_mode_o,
    // forced outputs
    output logic force_en_o,
    output logic [31:0] force_pat_o,
    // alarm source
    input wire logic alarm_i,
    input wire logic [7:0] alarm_code_i,
    input wire logic [15:0] op_hours_i,
    input svc_pkg::svc_stat_t [`SVC_SNAP_N-1:0] status_i,
    output logic alarm_reset_o,
    // point table load
    input wire logic pt_load_i,
    input wire logic [2:0] pt_field_i,
    input wire logic [7:0] pt_idx_i,
    input wire logic [31:0] pt_data_i
);
    import svc_pkg::*;

    svc_pos_t pos_state;
    logic [7:0] cur_alarm;
    logic [7:0] hist_code [`SVC_HIST_N];
    logic [15:0] hist_hours [`SVC_HIST_N];
    svc_stat_t snap [`SVC_SNAP_N];
    logic [31:0] pt_mem [`SVC_PT_FIELDS][PT_DEPTH];
    logic [31:0] wdog_cnt;

    svc_rsp_t next_rsp;
    logic do_stop, do_go, do_clr, do_mode, do_force, do_hclr, do_aclr;
    logic [2:0] next_mode;
    logic [7:0] dn;
    logic [31:0] dat;
    logic key_ok;
    logic [2:0] pt_f;

    assign dn = cmd_i.dnum;
    assign dat = cmd_i.data;
    assign key_ok = (dat[15:0] == `SVC_KEY);

    always_comb begin
        next_rsp = '0;
        do_stop = 1'b0;
        do_go = 1'b0;
        do_clr = 1'b0;
        do_mode = 1'b0;
        do_force = 1'b0;
        do_hclr = 1'b0;
        do_aclr = 1'b0;
        next_mode = test_mode_o;
        pt_f = 3'h0;
        case (cmd_i.code)
            `SVC_CMD_CUR_ALM: begin
                if (dn == `SVC_DN_ZERO) begin
                    next_rsp.data = {24'h000000, cur_alarm};
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_STAT_RD: begin
                if (dn == `SVC_DN_MODE) begin
                    next_rsp.data = {29'h0, test_mode_o};
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_STS_RD: begin
                if (dn == `SVC_DN_STS) begin
                    next_rsp.data[`SVC_HOME_BIT] =
                        home_return_done_flag_i;
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_HIST_RD: begin
                if (dn >= `SVC_DN_HCODE_LO && dn <= `SVC_DN_HCODE_HI) begin
                    next_rsp.data = {24'h000000,
                        hist_code[dn[2:0]]};
                end else if (dn >= `SVC_DN_HTIME_LO &&
                             dn <= `SVC_DN_HTIME_HI) begin
                    next_rsp.data = {16'h0000,
                        hist_hours[dn[2:0]]};
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_SNAP_RD: begin
                if (dn >= `SVC_DN_SNAP_LO && dn <= `SVC_DN_SNAP_HI) begin
                    next_rsp.data = snap[dn[3:0]].value;
                    next_rsp.info = snap[dn[3:0]].info;
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_CLEAR: begin
                if (dn == `SVC_DN_ZERO && key_ok) begin
                    do_aclr = 1'b1;
                end else if (dn == `SVC_DN_HCLR && key_ok) begin
                    do_hclr = 1'b1;
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_TEST: begin
                if (dn != `SVC_DN_ZERO || dat > 32'h00000005) begin
                    next_rsp.err = 1'b1;
                end else if (test_mode_o == SVC_MODE_MOTORLESS) begin
                    next_mode = SVC_MODE_MOTORLESS;
                end else begin
                    do_mode = 1'b1;
                    next_mode = dat[2:0];
                end
            end
            `SVC_CMD_FORCE: begin
                if (dn == `SVC_DN_FORCE && test_mode_o == SVC_MODE_FORCE) begin
                    do_force = 1'b1;
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_POS: begin
                if (dn != `SVC_DN_POS) begin
                    next_rsp.err = 1'b1;
                end else if (dat == `SVC_TXT_STOP && pos_running_i &&
                             pos_state == SVC_PS_FREE) begin
                    do_stop = 1'b1;
                end else if (dat == `SVC_TXT_GO &&
                             pos_state == SVC_PS_HOLD) begin
                    do_go = 1'b1;
                end else if (dat == `SVC_TXT_BLANK &&
                             pos_state == SVC_PS_HOLD) begin
                    do_clr = 1'b1;
                end else begin
                    next_rsp.err = 1'b1;
                end
            end
            `SVC_CMD_PT_POS, `SVC_CMD_PT_SPD, `SVC_CMD_PT_ACC,
            `SVC_CMD_PT_DEC, `SVC_CMD_PT_DWL, `SVC_CMD_PT_AUX: begin
                case (cmd_i.code)
                    `SVC_CMD_PT_POS: pt_f = 3'h0;
                    `SVC_CMD_PT_SPD: pt_f = 3'h1;
                    `SVC_CMD_PT_ACC: pt_f = 3'h2;
                    `SVC_CMD_PT_DEC: pt_f = 3'h3;
                    `SVC_CMD_PT_DWL: pt_f = 3'h4;
                    default: pt_f = 3'h5;
                endcase
                if (dn == `SVC_DN_ZERO || int'(dn) >= PT_DEPTH) begin
                    next_rsp.err = 1'b1;
                end else begin
                    next_rsp.data = pt_mem[pt_f][dn];
                end
            end
            default: begin
                next_rsp.err = 1'b1;
            end
        endcase
    end

    // reply register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
            if (cmd_valid_i) begin
                rsp_o <= next_rsp;
            end
        end
    end

    // temporary stop, restart and remaining distance clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pos_state <= SVC_PS_FREE;
            pos_hold_o <= 1'b0;
            pos_resume_o <= 1'b0;
            pos_clear_o <= 1'b0;
        end else begin
            pos_resume_o <= cmd_valid_i && do_go;
            pos_clear_o <= cmd_valid_i && do_clr;
            case (pos_state)
                SVC_PS_FREE: begin
                    if (cmd_valid_i && do_stop) begin
                        pos_state <= SVC_PS_HOLD;
                        pos_hold_o <= 1'b1;
                    end
                end
                SVC_PS_HOLD: begin
                    if (cmd_valid_i && (do_go || do_clr)) begin
                        pos_state <= SVC_PS_FREE;
                        pos_hold_o <= 1'b0;
                    end
                end
                default: begin
                    pos_state <= SVC_PS_FREE;
                    pos_hold_o <= 1'b0;
                end
            endcase
        end
    end

    // test mode selection; motorless ends only with reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            test_mode_o <= SVC_MODE_NORMAL;
        end else if (cmd_valid_i && do_mode) begin
            test_mode_o <= svc_mode_t'(next_mode);
        end
    end

    // forced output drive
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            force_en_o <= 1'b0;
            force_pat_o <= 32'h00000000;
        end else if (cmd_valid_i && do_mode) begin
            force_en_o <= (next_mode == SVC_MODE_FORCE);
            force_pat_o <= 32'h00000000;
        end else if (cmd_valid_i && do_force) begin
            force_pat_o <= dat;
        end
    end

    // communication watchdog in test mode
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wdog_cnt <= 32'h00000000;
            test_stop_o <= 1'b0;
        end else if (cmd_valid_i || test_mode_o == SVC_MODE_NORMAL) begin
            wdog_cnt <= 32'h00000000;
            test_stop_o <= 1'b0;
        end else if (wdog_cnt >= 32'(WDOG_CYC)) begin
            test_stop_o <= 1'b1;
        end else begin
            wdog_cnt <= wdog_cnt + 32'h00000001;
        end
    end

    // current alarm; a new alarm wins over a clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cur_alarm <= `SVC_NO_ALARM;
            alarm_reset_o <= 1'b0;
        end else begin
            alarm_reset_o <= cmd_valid_i && do_aclr;
            if (alarm_i) begin
                cur_alarm <= alarm_code_i;
            end else if (cmd_valid_i && do_aclr) begin
                cur_alarm <= `SVC_NO_ALARM;
            end
        end
    end

    // alarm history and status snapshot
    genvar gi;
    generate
        for (gi = 0; gi < `SVC_HIST_N; gi++) begin : g_hist
            always_ff @(posedge core_clk_i) begin
                if (rst_i || (cmd_valid_i && do_hclr && !alarm_i)) begin
                    hist_code[gi] <= `SVC_NO_ALARM;
                    hist_hours[gi] <= 16'h0000;
                end else if (alarm_i) begin
                    if (gi == 0) begin
                        hist_code[gi] <= alarm_code_i;
                        hist_hours[gi] <= op_hours_i;
                    end else if (cmd_valid_i && do_hclr) begin
                        hist_code[gi] <= `SVC_NO_ALARM;
                        hist_hours[gi] <= 16'h0000;
                    end else begin
                        hist_code[gi] <= hist_code[(gi == 0) ? 0 : gi - 1];
                        hist_hours[gi] <= hist_hours[(gi == 0) ? 0 : gi - 1];
                    end
                end
            end
        end
        for (gi = 0; gi < `SVC_SNAP_N; gi++) begin : g_snap
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    snap[gi] <= '0;
                end else if (alarm_i) begin
                    snap[gi] <= status_i[gi];
                end
            end
        end
    endgenerate

    // point table store, loaded by the drive side
    always_ff @(posedge core_clk_i) begin
        if (pt_load_i && int'(pt_field_i) < `SVC_PT_FIELDS &&
            int'(pt_idx_i) < PT_DEPTH) begin
            pt_mem[pt_field_i][pt_idx_i] <= pt_data_i;
        end
    end

endmodule : svc_cmd_core

// *** svc_cmd_core_assertions.sv ***
// port checker for the servo command interpreter
// assumes a bind from the testbench top, consts header on the path
`timescale 1ns/100ps
`include "svc_consts.svh"
module svc_chk (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // command and reply
    input wire logic cmd_valid_i,
    input svc_pkg::svc_cmd_t cmd_i,
    input wire logic rsp_valid_o,
    input svc_pkg::svc_rsp_t rsp_o,
    // motion, modes and alarm reset
    input wire logic pos_running_i,
    input wire logic pos_hold_o,
    input wire logic pos_resume_o,
    input wire logic pos_clear_o,
    input svc_pkg::svc_mode_t test_mode_o,
    input wire logic force_en_o,
    input wire logic alarm_reset_o
);
    import svc_pkg::*;
    logic is_pos;
    logic is_sel;
    logic clr_ok;
    assign is_pos = cmd_valid_i && cmd_i.code == `SVC_CMD_POS
        && cmd_i.dnum == `SVC_DN_POS;
    assign is_sel = cmd_valid_i && cmd_i.code == `SVC_CMD_TEST
        && cmd_i.dnum == 8'h00 && test_mode_o != SVC_MODE_MOTORLESS;
    assign clr_ok = cmd_valid_i && cmd_i.code == `SVC_CMD_CLEAR
        && cmd_i.dnum == 8'h00 && cmd_i.data[15:0] == `SVC_KEY;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_reply_next:
    assert property (cmd_valid_i |=> rsp_valid_o) else $error("no reply");
    a_no_stray_reply:
    assert property (rsp_valid_o |-> $past(cmd_valid_i))
        else $error("reply without command");
    a_stop_holds:
    assert property (is_pos && cmd_i.data == `SVC_TXT_STOP && pos_running_i
        && !pos_hold_o |=> pos_hold_o && !rsp_o.err) else $error("no hold");
    a_go_resumes:
    assert property (is_pos && cmd_i.data == `SVC_TXT_GO && pos_hold_o
        |=> pos_resume_o && !pos_hold_o ##1 !pos_resume_o)
        else $error("bad resume");
    a_blank_clears:
    assert property (is_pos && cmd_i.data == `SVC_TXT_BLANK && pos_hold_o
        |=> pos_clear_o && !pos_hold_o ##1 !pos_clear_o)
        else $error("bad clear");
    a_force_entry:
    assert property (is_sel && cmd_i.data == 32'h4
        |=> force_en_o && test_mode_o == SVC_MODE_FORCE)
        else $error("forced mode not entered");
    a_force_exit:
    assert property (is_sel && cmd_i.data == 32'h0
        |=> !force_en_o && test_mode_o == SVC_MODE_NORMAL)
        else $error("forced mode not left");
    a_motorless_stays:
    assert property (test_mode_o == SVC_MODE_MOTORLESS
        |=> test_mode_o == SVC_MODE_MOTORLESS) else $error("motorless left");
    a_alarm_clear:
    assert property (alarm_reset_o == $past(clr_ok))
        else $error("alarm reset pulse wrong");
endmodule : svc_chk

// *** svc_master.sv ***
// master station model: sends one command, collects its reply
// assumes the reply comes one edge after the taking edge
`timescale 1ns/100ps
module svc_master (
    // clock
    input wire logic core_clk_i,
    // command out
    output logic cmd_valid_o,
    output svc_pkg::svc_cmd_t cmd_o,
    // reply in
    input wire logic rsp_valid_i,
    input svc_pkg::svc_rsp_t rsp_i
);
    import svc_pkg::*;
    svc_rsp_t last;
    logic got;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    task automatic send(input logic [7:0] c, input logic [7:0] d,
                        input logic [31:0] v);
        @(negedge core_clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = '{code: c, dnum: d, data: v};
        @(negedge core_clk_i);
        cmd_valid_o = 1'b0;
        // released lines never keep the last value
        cmd_o = ~cmd_o;
        got = rsp_valid_i;
        last = rsp_i;
    endtask : send
endmodule : svc_master

// *** svc_cmd_core_tb.sv ***
// self-checking bench for the servo command interpreter
// assumes svc_pkg, svc_master and svc_chk compiled first
`timescale 1ns/100ps
`include "svc_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module svc_cmd_core_tb;
    import svc_pkg::*;
    localparam int WD = 20;
    localparam logic [7:0] PT_CODE [6] = '{8'h40, 8'h50, 8'h54, 8'h58,
        8'h60, 8'h64};
    localparam logic [31:0] MODES [4] = '{32'h1, 32'h2, 32'h4, 32'h5};
    logic core_clk_i, rst_i, cmd_valid_i, rsp_valid_o, pos_running_i;
    logic home_return_done_flag_i, pos_hold_o, pos_resume_o, pos_clear_o;
    logic test_stop_o, force_en_o, alarm_i, alarm_reset_o, pt_load_i;
    logic [31:0] force_pat_o, pt_data_i;
    logic [7:0] alarm_code_i, pt_idx_i;
    logic [15:0] op_hours_i;
    logic [2:0] pt_field_i;
    svc_cmd_t cmd_i;
    svc_rsp_t rsp_o;
    svc_mode_t test_mode_o;
    svc_stat_t [`SVC_SNAP_N-1:0] status_i;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    svc_cmd_core #(.WDOG_CYC(WD)) i_dut (.core_clk_i, .rst_i, .cmd_valid_i,
        .cmd_i, .rsp_valid_o, .rsp_o, .pos_running_i,
        .home_return_done_flag_i, .pos_hold_o, .pos_resume_o, .pos_clear_o,
        .test_stop_o, .test_mode_o, .force_en_o, .force_pat_o, .alarm_i,
        .alarm_code_i, .op_hours_i, .status_i, .alarm_reset_o, .pt_load_i,
        .pt_field_i, .pt_idx_i, .pt_data_i);
    svc_master i_mst (.core_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
        .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o));
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic tx(input logic [7:0] c, input logic [7:0] d,
                      input logic [31:0] v, input logic e);
        i_mst.send(c, d, v);
        `CHK("reply", 1'b1, i_mst.got)
        `CHK("err", e, i_mst.last.err)
    endtask : tx
    task automatic alarm(input logic [7:0] code);
        @(negedge core_clk_i);
        alarm_code_i = code;
        alarm_i = 1'b1;
        @(negedge core_clk_i);
        alarm_i = 1'b0;
    endtask : alarm
    task automatic t_pos;
        pos_running_i = 1'b1;
        tx(8'hA0, 8'h41, `SVC_TXT_GO, 1'b1);
        tx(8'hA0, 8'h41, `SVC_TXT_STOP, 1'b0);
        `CHK("hold", 1'b1, pos_hold_o)
        tx(8'hA0, 8'h41, `SVC_TXT_STOP, 1'b1);
        tx(8'hA0, 8'h41, `SVC_TXT_GO, 1'b0);
        `CHK("resume", 1'b1, pos_resume_o)
        tx(8'hA0, 8'h41, `SVC_TXT_STOP, 1'b0);
        tx(8'hA0, 8'h41, `SVC_TXT_BLANK, 1'b0);
        `CHK("clear", 1'b1, pos_clear_o)
        `CHK("hold", 1'b0, pos_hold_o)
        pos_running_i = 1'b0;
        tx(8'hA0, 8'h41, `SVC_TXT_STOP, 1'b1);
    endtask : t_pos
    task automatic t_alarm;
        op_hours_i = 16'h01F5;
        status_i[1] = '{info: 8'h0C, value: 32'h0000_1234};
        alarm(8'h32);
        alarm(8'h45);
        tx(8'h02, 8'h00, 32'h0, 1'b0);
        `CHK("cur", 32'h45, i_mst.last.data)
        tx(8'h33, 8'h11, 32'h0, 1'b0);
        `CHK("hist1", 32'h32, i_mst.last.data)
        tx(8'h33, 8'h15, 32'h0, 1'b0);
        `CHK("hist5", 32'hFF, i_mst.last.data)
        tx(8'h33, 8'h20, 32'h0, 1'b0);
        `CHK("hours", 32'h1F5, i_mst.last.data)
        tx(8'h33, 8'h16, 32'h0, 1'b1);
        tx(8'h35, 8'h81, 32'h0, 1'b0);
        `CHK("snap", 32'h1234, i_mst.last.data)
        `CHK("info", 8'h0C, i_mst.last.info)
        tx(8'h35, 8'h8F, 32'h0, 1'b1);
        tx(8'h82, 8'h00, 32'h1EA4, 1'b1);
        `CHK("arst", 1'b0, alarm_reset_o)
        tx(8'h82, 8'h00, 32'h1EA5, 1'b0);
        `CHK("arst", 1'b1, alarm_reset_o)
        tx(8'h02, 8'h00, 32'h0, 1'b0);
        `CHK("cur", 32'hFF, i_mst.last.data)
        tx(8'h82, 8'h20, 32'h1EA5, 1'b0);
        tx(8'h33, 8'h10, 32'h0, 1'b0);
        `CHK("hist0", 32'hFF, i_mst.last.data)
    endtask : t_alarm
    task automatic t_table;
        for (int f = 0; f < 6; f++) begin
            @(negedge core_clk_i);
            pt_load_i = 1'b1;
            pt_field_i = 3'(f);
            pt_data_i = 32'h100 + 32'(f);
        end
        @(negedge core_clk_i);
        pt_load_i = 1'b0;
        foreach (PT_CODE[f]) begin
            tx(PT_CODE[f], 8'hFF, 32'h0, 1'b0);
            `CHK("ptab", 32'h100 + 32'(f), i_mst.last.data)
        end
        tx(8'h40, 8'h00, 32'h0, 1'b1);
    endtask : t_table
    task automatic t_modes;
        home_return_done_flag_i = 1'b0;
        tx(8'h12, 8'h80, 32'h0, 1'b0);
        `CHK("home", 1'b0, i_mst.last.data[17])
        home_return_done_flag_i = 1'b1;
        tx(8'h12, 8'h80, 32'h0, 1'b0);
        `CHK("home", 1'b1, i_mst.last.data[17])
        foreach (MODES[m]) begin
            tx(8'h8B, 8'h00, MODES[m], 1'b0);
            tx(8'h00, 8'h12, 32'h0, 1'b0);
            `CHK("mode", MODES[m], i_mst.last.data)
        end
        tx(8'h8B, 8'h00, 32'h6, 1'b1);
        tx(8'h92, 8'hA0, 32'h0000_00A5, 1'b1);
        tx(8'h8B, 8'h00, 32'h4, 1'b0);
        tx(8'h92, 8'hA0, 32'h8000_0001, 1'b0);
        `CHK("pattern", 32'h8000_0001, force_pat_o)
        tx(8'h8B, 8'h00, 32'h0, 1'b0);
        `CHK("force", 1'b0, force_en_o)
        tx(8'h8B, 8'h00, 32'h3, 1'b0);
        tx(8'h8B, 8'h00, 32'h0, 1'b0);
        `CHK("mode", SVC_MODE_MOTORLESS, test_mode_o)
        repeat (WD) @(negedge core_clk_i);
        `CHK("wdog", 1'b0, test_stop_o)
        @(negedge core_clk_i);
        `CHK("wdog", 1'b1, test_stop_o)
        tx(8'h00, 8'h12, 32'h0, 1'b0);
        `CHK("wdog", 1'b0, test_stop_o)
    endtask : t_modes
    task automatic do_reset;
        rst_i = 1'b1;
        repeat (10) @(negedge core_clk_i);
        rst_i = 1'b0;
    endtask : do_reset
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        {rst_i, pos_running_i, alarm_i, pt_load_i, pt_field_i} = '0;
        {alarm_code_i, op_hours_i, status_i, pt_data_i} = '0;
        home_return_done_flag_i = 1'b1;
        pt_idx_i = 8'hFF;
        do_reset();
        t_pos();
        t_alarm();
        t_table();
        t_modes();
        do_reset();
        `CHK("mode", SVC_MODE_NORMAL, test_mode_o)
        close_out();
    end
endmodule : svc_cmd_core_tb
bind svc_cmd_core svc_chk i_chk (.core_clk_i, .rst_i, .cmd_valid_i, .cmd_i,
    .rsp_valid_o, .rsp_o, .pos_running_i, .pos_hold_o, .pos_resume_o,
    .pos_clear_o, .test_mode_o, .force_en_o, .alarm_reset_o);
